// ==== src/mps_params.svh ====
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH
// ************************************************************
// register map (byte addresses, one 32-bit word each)
// ************************************************************
`define MPS_REG_CTRL 8'h00
`define MPS_REG_FLAGS 8'h04
`define MPS_REG_MASK 8'h08
`define MPS_REG_STATE 8'h0C
`define MPS_REG_TIMEOUT 8'h10
`define MPS_REG_SPDMAX 8'h14
`define MPS_REG_VOUT 8'h18
`define MPS_REG_COIL 8'h1C
// ************************************************************
// field positions
// ************************************************************
`define MPS_CTRL_OC_LATCH 0
`define MPS_CTRL_OT_LATCH 1
`define MPS_CTRL_ARM 2
`define MPS_FLG_OC 0
`define MPS_FLG_OTC 1
`define MPS_FLG_OTM 2
`define MPS_FLG_CTO 3
`define MPS_FLG_WDG 4
`define MPS_FLG_OSB 5
`define MPS_NFLG 6
// ************************************************************
// reset values and timing
// ************************************************************
`define MPS_TIMEOUT_RST 16'h0064
`define MPS_SPDMAX_RST 16'h4000
`define MPS_CLK_NS 25
`define MPS_MS_NS 1000000
`define MPS_BOOT_MS 16'h000A
`define MPS_WD_MS 16'h0032
`define MPS_RESP_OKAY 2'h0
`define MPS_RESP_SLVERR 2'h2
`endif

// ==== src/mps_pkg.sv ====
`include "mps_params.svh"
package mps_pkg;
  // supervisor operating states
  typedef enum logic [1:0] {
    ST_BOOT,
    ST_UNARMED,
    ST_ARMED,
    ST_COAST
  } mps_state_e;

  // sensed quantities, all sampled on aclk
  typedef struct packed {
    logic [15:0] i_meas;
    logic [15:0] t_ctl;
    logic [15:0] speed;
    logic [15:0] vbus;
    logic regen;
  } mps_sense_s;

  // bridge drive request
  typedef struct packed {
    logic bridge_en;
    logic brake_all;
    logic coast;
    logic [15:0] v_apply;
  } mps_drive_s;

  // coil model state
  typedef struct packed {
    logic [15:0] temp;
  } mps_model_s;

  // whole supervisor state
  typedef struct packed {
    mps_state_e st;
    logic [15:0] div;
    logic [15:0] ms_cnt;
    logic [15:0] wd_cnt;
    logic tick;
    logic oc_latch;
    logic ot_latch;
    logic [`MPS_NFLG-1:0] flags;
    logic [`MPS_NFLG-1:0] mask;
    logic [15:0] timeout;
    logic [15:0] spd_max;
    logic [15:0] cmd_volt;
    mps_drive_s drive;
    logic derate;
    logic irq;
    logic armed;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mps_regs_s;
endpackage

// ==== src/mps_coil_model.sv ====
`timescale 1ns/1ps
`include "mps_params.svh"
// ************************************************************
// coil temperature estimator: first-order heat in, heat out
// ************************************************************
module mps_coil_model #(
  parameter logic [15:0] AMBIENT = 16'h0019,
  parameter int HEAT_SH = 4,
  parameter int COOL_SH = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic [15:0] i_meas,
  output logic [15:0] temp_est
);
  mps_pkg::mps_model_s r_reg; // registered estimate
  mps_pkg::mps_model_s r_next; // next estimate
  logic [17:0] acc; // wide sum, saturated below

  // integrate on each tick; saturation avoids wrap to a cold reading
  always_comb begin
    acc = '0;
    r_next = r_reg;
    if (tick) begin
      acc = {2'h0, r_reg.temp} + {2'h0, i_meas >> HEAT_SH};
      if (r_reg.temp > AMBIENT) begin
        acc = acc - {2'h0, (r_reg.temp - AMBIENT) >> COOL_SH};
      end
      r_next.temp = acc[17:16] != 2'h0 ? 16'hFFFF : acc[15:0];
    end
  end

  // state register; starts at ambient after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg.temp <= AMBIENT;
    end else begin
      r_reg <= r_next;
    end
  end

  assign temp_est = r_reg.temp;
endmodule

// ==== src/mps_supervisor.sv ====
`timescale 1ns/1ps
`include "mps_params.svh"
// Summary of operation
// - limit applied voltage to avoid overcurrent
// - overcurrent turns every bridge switch off
// - overcurrent latch optional, default non-latching
// - non-latching: recover once current below trip
// - derate output near controller temperature limit
// - leave derate when controller temperature drops
// - same derating on estimated coil temperature
// - overtemperature turns every bridge switch off
// - thermal latch optional, default non-latching
// - non-latching: resume once temperature below trip
// - overspeed lowers voltage, more when faster
// - extreme overspeed shorts all phases while armed and not tripped
// - excess regeneration limits applied voltage
// - command timeout disarms into coast
// - new command resumes after timeout
// - watchdog reboots into unarmed startup
module mps_supervisor #(
  parameter int unsigned MS_CYC = `MPS_MS_NS / `MPS_CLK_NS,
  parameter logic [15:0] I_TRIP = 16'h0F00,
  parameter logic [15:0] T_DER = 16'h0064,
  parameter logic [15:0] T_TRIP = 16'h0078,
  parameter logic [15:0] C_DER = 16'h00A0,
  parameter logic [15:0] C_TRIP = 16'h00B4,
  parameter logic [15:0] OS_BRAKE = 16'h0800,
  parameter logic [15:0] VBUS_MAX = 16'h3C00,
  parameter logic [15:0] VHEAD = 16'h0400,
  parameter int EMF_SH = 2,
  parameter int DER_SH = 6,
  parameter int OS_SH = 2,
  parameter int RG_SH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_volt,
  input wire logic wd_kick,
  input mps_pkg::mps_sense_s sense,
  output mps_pkg::mps_drive_s drive,
  output logic armed,
  output logic derate,
  output logic irq
);
  // ************************************************************
  // state and helpers
  // ************************************************************
  mps_pkg::mps_regs_s r_reg; // all state
  mps_pkg::mps_regs_s r_next; // next state
  logic [15:0] coil_temp; // coil estimate
  logic oc_now; // current above trip
  logic otc_now; // controller above trip
  logic otm_now; // coil above trip
  logic os_ext; // extreme overspeed
  logic oc_block; // overcurrent keeps bridge off
  logic ot_block; // temperature keeps bridge off
  logic wd_expire; // heartbeat lost
  logic to_expire; // command timeout reached
  logic [15:0] vlim; // permitted voltage
  logic [`MPS_NFLG-1:0] flg_set; // trip events
  logic [`MPS_NFLG-1:0] flg_clr; // host w1c
  logic wr_fire; // write performed this cycle
  logic [31:0] wr_word; // byte-merged write data

  // subtract with floor at zero; the amount may exceed 16 bits
  function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [31:0] b);
    sat_sub = (b >= {16'h0000, a}) ? 16'h0000 : a - b[15:0];
  endfunction

  // amount above a threshold, shifted into voltage units
  function automatic logic [31:0] excess(input logic [15:0] v, input logic [15:0] th,
                                         input int sh);
    excess = (v > th) ? ({16'h0000, v - th} << sh) : 32'h0000_0000;
  endfunction

  // merge write strobes into a 32-bit word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // ************************************************************
  // coil temperature model, stepped by the millisecond tick
  // ************************************************************
  mps_coil_model u_coil (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(r_reg.tick),
    .i_meas(sense.i_meas),
    .temp_est(coil_temp)
  );

  // ************************************************************
  // protection and register logic
  // ************************************************************
  always_comb begin
    r_next = r_reg;
    flg_set = '0;
    flg_clr = '0;
    wr_fire = 1'b0;
    wr_word = 32'h0000_0000;
    // millisecond enable from the clock divider
    r_next.tick = 1'b0;
    r_next.div = r_reg.div + 16'h0001;
    if (r_reg.div == 16'(MS_CYC - 1)) begin
      r_next.div = 16'h0000;
      r_next.tick = 1'b1;
    end
    // trip detection
    oc_now = sense.i_meas >= I_TRIP;
    otc_now = sense.t_ctl >= T_TRIP;
    otm_now = coil_temp >= C_TRIP;
    os_ext = {1'b0, sense.speed} > ({1'b0, r_reg.spd_max} + {1'b0, OS_BRAKE});
    flg_set[`MPS_FLG_OC] = oc_now;
    flg_set[`MPS_FLG_OTC] = otc_now;
    flg_set[`MPS_FLG_OTM] = otm_now;
    flg_set[`MPS_FLG_OSB] = os_ext && r_reg.st == mps_pkg::ST_ARMED;
    // latched flag holds the bridge off only in latching mode
    oc_block = oc_now || (r_reg.oc_latch && r_reg.flags[`MPS_FLG_OC]);
    ot_block = otc_now || otm_now || (r_reg.ot_latch &&
               (r_reg.flags[`MPS_FLG_OTC] || r_reg.flags[`MPS_FLG_OTM]));
    // predictive limit: back-emf plus a current headroom
    vlim = sat_sub(16'hFFFF, 32'h0000_FFFF - {16'h0000, sense.speed >> EMF_SH});
    vlim = (vlim > 16'hFFFF - VHEAD) ? 16'hFFFF : vlim + VHEAD;
    vlim = sat_sub(vlim, excess(sense.t_ctl, T_DER, DER_SH));
    vlim = sat_sub(vlim, excess(coil_temp, C_DER, DER_SH));
    vlim = sat_sub(vlim, excess(sense.speed, r_reg.spd_max, OS_SH));
    if (sense.regen) begin
      vlim = sat_sub(vlim, excess(sense.vbus, VBUS_MAX, RG_SH));
    end
    r_next.derate = sense.t_ctl >= T_DER || coil_temp >= C_DER;
    // latest commanded voltage
    if (cmd_valid) begin
      r_next.cmd_volt = cmd_volt;
    end
    // watchdog on the controller heartbeat
    wd_expire = r_reg.tick && r_reg.wd_cnt >= `MPS_WD_MS - 16'h0001 && !wd_kick;
    if (wd_kick) begin
      r_next.wd_cnt = 16'h0000;
    end else if (r_reg.tick) begin
      r_next.wd_cnt = r_reg.wd_cnt + 16'h0001;
    end
    // command timeout, counted in milliseconds; zero disables it
    to_expire = r_reg.st == mps_pkg::ST_ARMED && r_reg.timeout != 16'h0000 &&
                !cmd_valid && r_reg.tick && r_reg.ms_cnt >= r_reg.timeout - 16'h0001;
    if (cmd_valid && r_reg.st != mps_pkg::ST_BOOT) begin // traffic must not stall boot
      r_next.ms_cnt = 16'h0000;
    end else if (r_reg.tick) begin
      r_next.ms_cnt = r_reg.ms_cnt + 16'h0001;
    end
    // ----- AXI write channel: address and data in either order
    if (s_axi_awvalid && r_reg.awready) begin
      r_next.aw_have = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_reg.wready) begin
      r_next.w_have = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
      wr_fire = 1'b1;
      r_next.aw_have = 1'b0;
      r_next.w_have = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = `MPS_RESP_OKAY;
      if (r_reg.awaddr == `MPS_REG_CTRL) begin
        wr_word = merge({29'h0, 1'b0, r_reg.ot_latch, r_reg.oc_latch},
                        r_reg.wdata, r_reg.wstrb);
        r_next.oc_latch = wr_word[`MPS_CTRL_OC_LATCH];
        r_next.ot_latch = wr_word[`MPS_CTRL_OT_LATCH];
      end else if (r_reg.awaddr == `MPS_REG_FLAGS) begin
        wr_word = merge(32'h0000_0000, r_reg.wdata, r_reg.wstrb);
        flg_clr = wr_word[`MPS_NFLG-1:0];
      end else if (r_reg.awaddr == `MPS_REG_MASK) begin
        wr_word = merge({26'h0, r_reg.mask}, r_reg.wdata, r_reg.wstrb);
        r_next.mask = wr_word[`MPS_NFLG-1:0];
      end else if (r_reg.awaddr == `MPS_REG_TIMEOUT) begin
        wr_word = merge({16'h0, r_reg.timeout}, r_reg.wdata, r_reg.wstrb);
        r_next.timeout = wr_word[15:0];
      end else if (r_reg.awaddr == `MPS_REG_SPDMAX) begin
        wr_word = merge({16'h0, r_reg.spd_max}, r_reg.wdata, r_reg.wstrb);
        r_next.spd_max = wr_word[15:0];
      end else if (r_reg.awaddr == `MPS_REG_STATE || r_reg.awaddr == `MPS_REG_VOUT ||
                   r_reg.awaddr == `MPS_REG_COIL) begin
        r_next.bresp = `MPS_RESP_OKAY; // read-only: write ignored
      end else begin
        r_next.bresp = `MPS_RESP_SLVERR; // unmapped
      end
    end
    // ----- state machine
    case (r_reg.st)
      mps_pkg::ST_BOOT: begin
        // startup delay before the host may arm
        if (r_reg.tick) begin
          r_next.ms_cnt = r_reg.ms_cnt + 16'h0001;
          if (r_reg.ms_cnt >= `MPS_BOOT_MS - 16'h0001) begin
            r_next.st = mps_pkg::ST_UNARMED;
          end
        end
      end
      mps_pkg::ST_UNARMED: begin
        // arming only by explicit host write; rests on the host
        if (wr_fire && r_reg.awaddr == `MPS_REG_CTRL && r_reg.wstrb[0] &&
            r_reg.wdata[`MPS_CTRL_ARM]) begin
          r_next.st = mps_pkg::ST_ARMED;
          r_next.ms_cnt = 16'h0000;
        end
      end
      mps_pkg::ST_ARMED: begin
        if (to_expire) begin
          r_next.st = mps_pkg::ST_COAST;
          flg_set[`MPS_FLG_CTO] = 1'b1;
        end
      end
      mps_pkg::ST_COAST: begin
        if (cmd_valid) begin
          r_next.st = mps_pkg::ST_ARMED;
        end
      end
      default: begin
        r_next.st = mps_pkg::ST_BOOT;
      end
    endcase
    // watchdog overrides everything: restart the startup sequence
    if (wd_expire) begin
      r_next.st = mps_pkg::ST_BOOT;
      r_next.ms_cnt = 16'h0000;
      r_next.wd_cnt = 16'h0000;
      flg_set[`MPS_FLG_WDG] = 1'b1;
    end
    // sticky flags: an event in the clearing cycle survives
    r_next.flags = (r_reg.flags & ~flg_clr) | flg_set;
    r_next.irq = |(r_next.flags & r_next.mask);
    r_next.armed = r_next.st == mps_pkg::ST_ARMED; // kept in a flop for the pin
    // ----- drive outputs; any trip wins over braking
    r_next.drive.bridge_en = r_reg.st == mps_pkg::ST_ARMED && !oc_block && !ot_block;
    r_next.drive.brake_all = r_next.drive.bridge_en && os_ext;
    r_next.drive.coast = r_reg.st != mps_pkg::ST_ARMED;
    if (r_next.drive.bridge_en && !os_ext) begin
      r_next.drive.v_apply = (r_next.cmd_volt > vlim) ? vlim : r_next.cmd_volt;
    end else begin
      r_next.drive.v_apply = 16'h0000;
    end
    // ----- AXI read channel, one cycle to rvalid
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rresp = `MPS_RESP_OKAY;
      r_next.rdata = 32'h0000_0000;
      if (s_axi_araddr == `MPS_REG_CTRL) begin
        r_next.rdata = {30'h0, r_reg.ot_latch, r_reg.oc_latch};
      end else if (s_axi_araddr == `MPS_REG_FLAGS) begin
        r_next.rdata = {26'h0, r_reg.flags};
      end else if (s_axi_araddr == `MPS_REG_MASK) begin
        r_next.rdata = {26'h0, r_reg.mask};
      end else if (s_axi_araddr == `MPS_REG_STATE) begin
        r_next.rdata = {25'h0, r_reg.derate, r_reg.drive.coast, r_reg.drive.brake_all,
                        r_reg.drive.bridge_en, 1'b0, r_reg.st};
      end else if (s_axi_araddr == `MPS_REG_TIMEOUT) begin
        r_next.rdata = {16'h0, r_reg.timeout};
      end else if (s_axi_araddr == `MPS_REG_SPDMAX) begin
        r_next.rdata = {16'h0, r_reg.spd_max};
      end else if (s_axi_araddr == `MPS_REG_VOUT) begin
        r_next.rdata = {16'h0, r_reg.drive.v_apply};
      end else if (s_axi_araddr == `MPS_REG_COIL) begin
        r_next.rdata = {16'h0, coil_temp};
      end else begin
        r_next.rresp = `MPS_RESP_SLVERR; // unmapped
      end
    end
    // ready flags: one request of each kind in flight
    r_next.awready = !r_next.aw_have && !r_next.bvalid;
    r_next.wready = !r_next.w_have && !r_next.bvalid;
    r_next.arready = !r_next.rvalid;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.st <= mps_pkg::ST_BOOT;
      r_reg.timeout <= `MPS_TIMEOUT_RST;
      r_reg.spd_max <= `MPS_SPDMAX_RST;
      r_reg.drive.coast <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = r_reg.awready;
  assign s_axi_wready = r_reg.wready;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = r_reg.arready;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign drive = r_reg.drive;
  assign armed = r_reg.armed;
  assign derate = r_reg.derate;
  assign irq = r_reg.irq;

  // ************************************************************
  // checks
  // ************************************************************
  AST_VLIM: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> drive.v_apply <= $past(vlim)) else $error("applied voltage above limit");
  AST_OC_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    oc_now |=> !drive.bridge_en && drive.v_apply == 16'h0000) else $error("bridge on in oc");
  AST_OC_LATCH: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.oc_latch && r_reg.flags[`MPS_FLG_OC] |=> !drive.bridge_en)
    else $error("latched oc let bridge on");
  AST_RECOVER: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == mps_pkg::ST_ARMED && !oc_block && !ot_block |=> drive.bridge_en)
    else $error("bridge did not recover");
  AST_OT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (otc_now || otm_now) |=> !drive.bridge_en) else $error("bridge on in ot");
  AST_BRAKE: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == mps_pkg::ST_ARMED && os_ext && !oc_block && !ot_block
    |=> drive.brake_all && drive.v_apply == 16'h0000) else $error("no brake on overspeed");
  AST_TIMEOUT: assert property (@(posedge aclk) disable iff (!aresetn)
    to_expire && !wd_expire |=> r_reg.st == mps_pkg::ST_COAST ##1 drive.coast)
    else $error("timeout did not coast");
  AST_RESUME: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.st == mps_pkg::ST_COAST && cmd_valid && !wd_expire |=> armed)
    else $error("command did not resume");
  AST_WDOG: assert property (@(posedge aclk) disable iff (!aresetn)
    wd_expire |=> r_reg.st == mps_pkg::ST_BOOT && r_reg.flags[`MPS_FLG_WDG] && !armed)
    else $error("watchdog did not reboot");
  AST_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    r_reg.flags[`MPS_FLG_OC] && !flg_clr[`MPS_FLG_OC] |=> r_reg.flags[`MPS_FLG_OC])
    else $error("oc flag dropped without clear");
endmodule

// ==== dv/mps_host_model.sv ====
`timescale 1ns/1ps
// ************************************************************
// host model: one command message every fourth cycle when enabled
// ************************************************************
module mps_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en,
  input wire logic [15:0] volt,
  output logic cmd_valid,
  output logic [15:0] cmd_volt
);
  logic [1:0] cnt_reg; // spacing counter
  // the value lines churn between messages so no stale word looks valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 2'h0;
      cmd_valid <= 1'b0;
      cmd_volt <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      cmd_valid <= en && (cnt_reg == 2'h3);
      cmd_volt <= (en && (cnt_reg == 2'h3)) ? volt : ~cmd_volt;
    end
  end
endmodule

// ==== dv/mps_supervisor_tb_top.sv ====
`timescale 1ns/1ps
`include "mps_params.svh"
`define CHK(a, e) begin \
  tests_run++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); \
  end \
end
module mps_supervisor_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic cmd_valid, wd_kick, armed, derate, irq, host_en, wd_on;
  logic [15:0] cmd_volt, host_volt;
  logic [3:0] wd_cnt;
  logic [2:0] ph; // mirrors the design's millisecond divider (MS_CYC of 8)
  mps_pkg::mps_sense_s sense;
  mps_pkg::mps_drive_s drive;
  int miscompares, tests_run, cycles;
  // 1 ms is shortened to 8 cycles so boot and watchdog stay short
  mps_supervisor #(.MS_CYC(8)) u_mps_supervisor (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cmd_valid, .cmd_volt, .wd_kick,
    .sense, .drive, .armed, .derate, .irq);
  mps_host_model u_mps_host_model (.aclk, .aresetn, .en(host_en), .volt(host_volt),
    .cmd_valid, .cmd_volt);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // heartbeat every 16 cycles while enabled
  always @(posedge aclk) begin
    wd_cnt <= wd_cnt + 4'h1;
    wd_kick <= wd_on && (wd_cnt == 4'h0);
  end
  // divider phase; coil model steps on edges where ph reads zero
  always @(posedge aclk) begin
    ph <= aresetn ? ph + 3'h1 : 3'h0;
  end
  // hang guard: the whole run needs under 1000 cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("tests %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // a coil step at trip current would overheat the estimate for hundreds
  // of cycles, so short current pulses start just after a step
  task automatic sync_tick();
    do @(posedge aclk); while (ph !== 3'h1);
  endtask
  // ************************************************************
  // register bus master
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_data = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_unarmed();
    do rd(`MPS_REG_STATE); while (rd_data[1:0] !== 2'h1);
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    rd(`MPS_REG_TIMEOUT);
    `CHK(rd_data, 32'h00000064)
    rd(8'h20);
    `CHK(rsp, 2'h2)
    wr(8'h24, 32'h00000001);
    `CHK(rsp, 2'h2)
    `CHK(drive.coast, 1'b1)
    wait_unarmed();
    wr(`MPS_REG_TIMEOUT, 32'h00000002);
    wr(`MPS_REG_MASK, 32'h0000003F);
    wr(`MPS_REG_CTRL, 32'h00000004);
    cyc(2);
    `CHK(armed, 1'b1)
    $display("regs test done");
  endtask
  task automatic t_oc(input logic lat);
    wr(`MPS_REG_CTRL, {31'h0, lat});
    sync_tick();
    sense.i_meas <= 16'h0F00;
    cyc(2);
    `CHK(drive.bridge_en, 1'b0)
    cyc(1);
    `CHK(irq, 1'b1)
    sense.i_meas <= 16'h0010;
    cyc(3);
    `CHK(drive.bridge_en, ~lat)
    wr(`MPS_REG_FLAGS, 32'h00000001);
    cyc(3);
    `CHK(drive.bridge_en, 1'b1)
    `CHK(irq, 1'b0)
    wr(`MPS_REG_CTRL, 32'h00000000);
    $display("overcurrent test done");
  endtask
  task automatic t_therm();
    sense.t_ctl <= 16'h0070;
    cyc(4);
    `CHK(derate, 1'b1)
    `CHK(drive.v_apply < 16'h0200, 1'b1)
    sense.t_ctl <= 16'h0080;
    cyc(3);
    `CHK(drive.bridge_en, 1'b0)
    rd(`MPS_REG_FLAGS);
    `CHK(rd_data[1], 1'b1)
    sense.t_ctl <= 16'h0030;
    cyc(4);
    `CHK(drive.bridge_en, 1'b1)
    `CHK(derate, 1'b0)
    wr(`MPS_REG_FLAGS, 32'h00000002);
    wr(`MPS_REG_CTRL, 32'h00000002);
    sense.t_ctl <= 16'h0080;
    cyc(3);
    sense.t_ctl <= 16'h0030;
    cyc(4);
    `CHK(drive.bridge_en, 1'b0)
    wr(`MPS_REG_FLAGS, 32'h00000002);
    cyc(3);
    `CHK(drive.bridge_en, 1'b1)
    wr(`MPS_REG_CTRL, 32'h00000000);
    $display("thermal test done");
  endtask
  task automatic t_limit();
    host_volt <= 16'hFFFF;
    cyc(8);
    `CHK(drive.v_apply, 16'h0440)
    rd(`MPS_REG_VOUT);
    `CHK(rd_data, 32'h00000440)
    wr(`MPS_REG_SPDMAX, 32'h00000100);
    sense.speed <= 16'h0180;
    cyc(4);
    `CHK(drive.v_apply < 16'h0460, 1'b1)
    sense.speed <= 16'h0901;
    cyc(3);
    `CHK(drive.brake_all, 1'b1)
    sense.speed <= 16'h0100;
    wr(`MPS_REG_SPDMAX, 32'h00004000);
    sense.vbus <= 16'h3D00;
    sense.regen <= 1'b1;
    cyc(4);
    `CHK(drive.v_apply < 16'h0440, 1'b1)
    sense.vbus <= 16'h3000;
    sense.regen <= 1'b0;
    host_volt <= 16'h0200;
    wr(`MPS_REG_FLAGS, 32'h0000003F);
    $display("limit test done");
  endtask
  task automatic t_timeout();
    host_en <= 1'b0;
    cyc(40);
    `CHK(armed, 1'b0)
    `CHK(drive.coast, 1'b1)
    rd(`MPS_REG_FLAGS);
    `CHK(rd_data[3], 1'b1)
    host_en <= 1'b1;
    cyc(8);
    `CHK(armed, 1'b1)
    wr(`MPS_REG_FLAGS, 32'h00000008);
    $display("timeout test done");
  endtask
  task automatic t_wdog();
    wd_on <= 1'b0;
    cyc(440);
    `CHK(armed, 1'b0)
    rd(`MPS_REG_STATE);
    `CHK(rd_data[1:0], 2'h0)
    wd_on <= 1'b1;
    wait_unarmed();
    rd(`MPS_REG_FLAGS);
    `CHK(rd_data[4], 1'b1)
    wr(`MPS_REG_CTRL, 32'h00000004);
    cyc(2);
    `CHK(armed, 1'b1)
    $display("watchdog test done");
  endtask
  // moderate current heats the coil estimate into derate, short of a trip
  task automatic t_coil();
    sense.i_meas <= 16'h0100;
    for (int i = 0; i < 200 && derate !== 1'b1; i++) begin
      @(posedge aclk);
    end
    sense.i_meas <= 16'h0010;
    `CHK(derate, 1'b1)
    `CHK(drive.bridge_en, 1'b1)
    rd(`MPS_REG_STATE);
    `CHK(rd_data[6:3], 4'h9)
    $display("coil test done");
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h000000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    // idle current low enough that the coil estimate settles below derate
    sense = '{i_meas: 16'h0010, t_ctl: 16'h0030, speed: 16'h0100, vbus: 16'h3000, regen: 1'b0};
    {host_en, wd_on, wd_cnt, wd_kick, cycles, miscompares, tests_run} = '0;
    host_volt = 16'h0200;
    aresetn = 1'b0;
    cyc(8);
    aresetn <= 1'b1;
    host_en <= 1'b1;
    wd_on <= 1'b1;
    cyc(2);
    t_regs();
    t_oc(1'b0);
    t_oc(1'b1);
    t_therm();
    t_limit();
    t_timeout();
    t_wdog();
    t_coil();
    end_of_test();
  end
endmodule
